// ===== hdl/urxl_pkg.sv
// constants shared by the receive line control and baud divisor block
package urxl_pkg;
    // register byte addresses
    localparam logic [11:0] URXL_ADDR_LINE = 12'h01C;
    localparam logic [11:0] URXL_ADDR_DIV_INT = 12'h024;
    localparam logic [11:0] URXL_ADDR_DIV_FRAC = 12'h028;
    localparam logic [11:0] URXL_ADDR_CTRL = 12'h030;
    localparam logic [11:0] URXL_ADDR_STAT = 12'h034;
    localparam logic [11:0] URXL_ADDR_CLR = 12'h038;
    localparam logic [11:0] URXL_ADDR_IEN = 12'h03C;
    localparam logic [11:0] URXL_ADDR_DATA = 12'h040;
    // receive line control fields
    localparam int URXL_LINE_PAR_ON = 1;
    localparam int URXL_LINE_EVEN = 2;
    localparam int URXL_LINE_TWO_STOP = 3;
    localparam int URXL_LINE_QUEUE_ON = 4;
    localparam int URXL_LINE_LEN_LSB = 5;
    localparam int URXL_LINE_FIXED_PAR = 7;
    localparam int URXL_LINE_W = 8;
    localparam logic [7:0] URXL_LINE_RESET = 8'h00;
    // divisor fields
    localparam int URXL_DIV_INT_W = 16;
    localparam int URXL_DIV_FRAC_W = 6;
    // control fields
    localparam int URXL_CTRL_OVS = 0;
    localparam int URXL_CTRL_RX_ON = 1;
    localparam int URXL_CTRL_W = 2;
    // status, clear and enable share this layout
    localparam int URXL_ST_DONE = 0;
    localparam int URXL_ST_PERR = 1;
    localparam int URXL_ST_FERR = 2;
    localparam int URXL_ST_OVR = 3;
    localparam int URXL_ST_W = 4;
    // received data word
    localparam int URXL_DATA_PERR = 8;
    localparam int URXL_DATA_FERR = 9;
    localparam int URXL_DATA_EMPTY = 10;
    localparam int URXL_ENTRY_W = 10;
    // oversampling factors in ticks per bit
    localparam logic [4:0] URXL_OVS_16 = 5'h10;
    localparam logic [4:0] URXL_OVS_8 = 5'h08;
    // receive queue
    localparam int URXL_Q_AW = 3;
    localparam logic [3:0] URXL_Q_DEPTH = 4'h8;
    localparam logic [3:0] URXL_Q_CHAR = 4'h1;
    // receiver states, gray along start, data, parity, stop
    typedef enum logic [2:0] {
        URXL_IDLE = 3'b000,
        URXL_START = 3'b001,
        URXL_DATA = 3'b011,
        URXL_PARITY = 3'b010,
        URXL_STOP = 3'b110
    } urxl_state_t;
endpackage

// ===== hdl/urxl_baud_tick.sv
// fractional baud divisor producing the oversample tick
`timescale 1ns/100ps
`default_nettype none
module urxl_baud_tick (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divisor
    input wire logic run,
    input wire logic [urxl_pkg::URXL_DIV_INT_W-1:0] whole,
    input wire logic [urxl_pkg::URXL_DIV_FRAC_W-1:0] frac,
    // oversample tick
    output logic tick
);
    logic [urxl_pkg::URXL_DIV_INT_W:0] cnt;
    logic [urxl_pkg::URXL_DIV_FRAC_W-1:0] acc;
    logic [urxl_pkg::URXL_DIV_FRAC_W:0] sum;

    // the fraction accumulates in 1/64 steps; a carry stretches one period by a cycle
    assign sum = {1'b0, acc} + {1'b0, frac};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            acc <= '0;
            tick <= 1'b0;
        end else if (!run || whole == '0) begin
            cnt <= '0;
            acc <= '0;
            tick <= 1'b0;
        end else if (cnt <= 17'h00001) begin
            tick <= 1'b1;
            acc <= sum[urxl_pkg::URXL_DIV_FRAC_W-1:0];
            cnt <= {1'b0, whole} + {16'h0000, sum[urxl_pkg::URXL_DIV_FRAC_W]};
        end else begin
            tick <= 1'b0;
            cnt <= cnt - 17'h00001;
        end
    end

    // a divisor swap between characters may leave one back-to-back tick from the old count
    a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && run && whole > 16'h0001 && $stable(whole)) |=> !tick)
        else $error("oversample tick repeated too soon");
endmodule
`default_nettype wire

// ===== hdl/urxl_top.sv
// uart receive line control, baud divisor and apb register file
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module urxl_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic rx_line,
    // status
    output logic rx_busy,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [urxl_pkg::URXL_LINE_W-1:0] line_ctl;
    logic [urxl_pkg::URXL_DIV_INT_W-1:0] div_int;
    logic [urxl_pkg::URXL_DIV_FRAC_W-1:0] div_frac;
    logic [urxl_pkg::URXL_CTRL_W-1:0] ctrl;
    logic [urxl_pkg::URXL_ST_W-1:0] status;
    logic [urxl_pkg::URXL_ST_W-1:0] ien;
    logic [urxl_pkg::URXL_DIV_INT_W-1:0] act_int;
    logic [urxl_pkg::URXL_DIV_FRAC_W-1:0] act_frac;
    logic act_ovs;
    logic tick;
    urxl_pkg::urxl_state_t state;
    logic [4:0] os_cnt;
    logic [4:0] ovs;
    logic [2:0] bit_idx;
    logic [2:0] last_idx;
    logic [2:0] len_m1;
    logic [7:0] shreg;
    logic cfg_par_on;
    logic cfg_even;
    logic cfg_two_stop;
    logic cfg_fixed;
    logic stop_left;
    logic frame_perr;
    logic frame_ferr;
    logic char_done;
    logic samp;
    logic half;
    logic exp_par;
    logic [urxl_pkg::URXL_ENTRY_W-1:0] queue [0:7];
    logic [urxl_pkg::URXL_Q_AW-1:0] wr_ptr;
    logic [urxl_pkg::URXL_Q_AW-1:0] rd_ptr;
    logic [3:0] q_cnt;
    logic [3:0] q_cap;
    logic push_ok;
    logic pop;
    logic acc_done;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [31:0] rd_val;
    logic [urxl_pkg::URXL_ST_W-1:0] ev_set;
    logic [urxl_pkg::URXL_ST_W-1:0] ev_clr;
    logic [1:0] stop_seen;

    ////////////////////////////////////////////////////////////////////////////
    // apb access: one wait state, writes land on the completing edge
    assign acc_done = psel && penable && pready;
    assign wr_en = acc_done && pwrite;
    assign rd_en = acc_done && !pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            urxl_pkg::URXL_ADDR_LINE: rd_val[urxl_pkg::URXL_LINE_W-1:0] = line_ctl;
            urxl_pkg::URXL_ADDR_DIV_INT: rd_val[urxl_pkg::URXL_DIV_INT_W-1:0] = div_int;
            urxl_pkg::URXL_ADDR_DIV_FRAC: rd_val[urxl_pkg::URXL_DIV_FRAC_W-1:0] = div_frac;
            urxl_pkg::URXL_ADDR_CTRL: rd_val[urxl_pkg::URXL_CTRL_W-1:0] = ctrl;
            urxl_pkg::URXL_ADDR_STAT: rd_val[urxl_pkg::URXL_ST_W-1:0] = status;
            urxl_pkg::URXL_ADDR_CLR: rd_val = 32'h0000_0000;
            urxl_pkg::URXL_ADDR_IEN: rd_val[urxl_pkg::URXL_ST_W-1:0] = ien;
            urxl_pkg::URXL_ADDR_DATA: begin
                rd_val[urxl_pkg::URXL_ENTRY_W-1:0] = (q_cnt != 4'h0) ? queue[rd_ptr] : '0;
                rd_val[urxl_pkg::URXL_DATA_EMPTY] = (q_cnt == 4'h0);
            end
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !mapped;
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ctl <= urxl_pkg::URXL_LINE_RESET;
            div_int <= '0;
            div_frac <= '0;
            ctrl <= '0;
            ien <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                urxl_pkg::URXL_ADDR_LINE: line_ctl <= pwdata[urxl_pkg::URXL_LINE_W-1:0];
                urxl_pkg::URXL_ADDR_DIV_INT: div_int <= pwdata[urxl_pkg::URXL_DIV_INT_W-1:0];
                urxl_pkg::URXL_ADDR_DIV_FRAC: div_frac <= pwdata[urxl_pkg::URXL_DIV_FRAC_W-1:0];
                urxl_pkg::URXL_ADDR_CTRL: ctrl <= pwdata[urxl_pkg::URXL_CTRL_W-1:0];
                urxl_pkg::URXL_ADDR_IEN: ien <= pwdata[urxl_pkg::URXL_ST_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divisor only follows software between characters, so a frame never changes rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_int <= '0;
            act_frac <= '0;
            act_ovs <= 1'b0;
        end else if (state == urxl_pkg::URXL_IDLE) begin
            act_int <= div_int;
            act_frac <= div_frac;
            act_ovs <= ctrl[urxl_pkg::URXL_CTRL_OVS];
        end
    end

    urxl_baud_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl[urxl_pkg::URXL_CTRL_RX_ON]),
        .whole(act_int),
        .frac(act_frac),
        .tick(tick)
    );

    // tick is clock over divisor; a bit lasts 16 or 8 ticks
    assign ovs = act_ovs ? urxl_pkg::URXL_OVS_8 : urxl_pkg::URXL_OVS_16;
    assign samp = tick && (os_cnt == ovs - 5'h01);
    assign half = tick && (os_cnt == (ovs >> 1) - 5'h01);
    assign len_m1 = {1'b1, line_ctl[urxl_pkg::URXL_LINE_LEN_LSB +: 2]};
    // fixed parity overrides the computed one
    assign exp_par = cfg_fixed ? !cfg_even : (cfg_even ? ^shreg : !(^shreg));

    ////////////////////////////////////////////////////////////////////////////
    // receive frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= urxl_pkg::URXL_IDLE;
            os_cnt <= '0;
            bit_idx <= '0;
            last_idx <= '0;
            shreg <= '0;
            cfg_par_on <= 1'b0;
            cfg_even <= 1'b0;
            cfg_two_stop <= 1'b0;
            cfg_fixed <= 1'b0;
            stop_left <= 1'b0;
            frame_perr <= 1'b0;
            frame_ferr <= 1'b0;
            char_done <= 1'b0;
            rx_busy <= 1'b0;
        end else begin
            char_done <= 1'b0;
            unique case (state)
                urxl_pkg::URXL_IDLE: begin
                    rx_busy <= 1'b0;
                    if (ctrl[urxl_pkg::URXL_CTRL_RX_ON] && !rx_line && act_int != '0) begin
                        state <= urxl_pkg::URXL_START;
                        rx_busy <= 1'b1;
                        os_cnt <= '0;
                        shreg <= '0;
                        frame_perr <= 1'b0;
                        frame_ferr <= 1'b0;
                        cfg_par_on <= line_ctl[urxl_pkg::URXL_LINE_PAR_ON];
                        cfg_even <= line_ctl[urxl_pkg::URXL_LINE_EVEN];
                        cfg_two_stop <= line_ctl[urxl_pkg::URXL_LINE_TWO_STOP];
                        cfg_fixed <= line_ctl[urxl_pkg::URXL_LINE_FIXED_PAR];
                        bit_idx <= 3'h0;
                        // length is frozen per frame, so a mid-frame write cannot cut a character
                        last_idx <= len_m1;
                    end
                end
                urxl_pkg::URXL_START: begin
                    if (half) begin
                        os_cnt <= '0;
                        // a glitch shorter than half a bit is not a start
                        state <= rx_line ? urxl_pkg::URXL_IDLE : urxl_pkg::URXL_DATA;
                    end else if (tick) begin
                        os_cnt <= os_cnt + 5'h01;
                    end
                end
                urxl_pkg::URXL_DATA: begin
                    if (samp) begin
                        os_cnt <= '0;
                        shreg[bit_idx] <= rx_line;
                        if (bit_idx == last_idx) begin
                            state <= cfg_par_on ? urxl_pkg::URXL_PARITY : urxl_pkg::URXL_STOP;
                            stop_left <= cfg_two_stop;
                        end else begin
                            bit_idx <= bit_idx + 3'h1;
                        end
                    end else if (tick) begin
                        os_cnt <= os_cnt + 5'h01;
                    end
                end
                urxl_pkg::URXL_PARITY: begin
                    if (samp) begin
                        os_cnt <= '0;
                        frame_perr <= (rx_line != exp_par);
                        state <= urxl_pkg::URXL_STOP;
                    end else if (tick) begin
                        os_cnt <= os_cnt + 5'h01;
                    end
                end
                urxl_pkg::URXL_STOP: begin
                    if (samp) begin
                        os_cnt <= '0;
                        if (!rx_line) begin
                            frame_ferr <= 1'b1;
                        end
                        if (stop_left) begin
                            stop_left <= 1'b0;
                        end else begin
                            state <= urxl_pkg::URXL_IDLE;
                            char_done <= 1'b1;
                        end
                    end else if (tick) begin
                        os_cnt <= os_cnt + 5'h01;
                    end
                end
                default: state <= urxl_pkg::URXL_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive queue: depth 8 with the queue on, a single holding word otherwise
    assign q_cap = line_ctl[urxl_pkg::URXL_LINE_QUEUE_ON] ? urxl_pkg::URXL_Q_DEPTH : urxl_pkg::URXL_Q_CHAR;
    assign pop = rd_en && (paddr == urxl_pkg::URXL_ADDR_DATA) && (q_cnt != 4'h0);
    // a read in the same cycle frees the slot, so no overrun then
    assign push_ok = char_done && ((q_cnt < q_cap) || pop);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            q_cnt <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            unique case ({push_ok, pop})
                2'b10: q_cnt <= q_cnt + 4'h1;
                2'b01: q_cnt <= q_cnt - 4'h1;
                default: ;
            endcase
        end
    end

    // the array holds no control state and needs no reset
    always_ff @(posedge pclk) begin
        if (push_ok) begin
            queue[wr_ptr] <= {frame_ferr, frame_perr, shreg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events; a set in the clearing cycle wins
    assign ev_set = {char_done && !push_ok, char_done && frame_ferr, char_done && frame_perr, push_ok};
    assign ev_clr = (wr_en && paddr == urxl_pkg::URXL_ADDR_CLR) ? pwdata[urxl_pkg::URXL_ST_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= (status & ~ev_clr) | ev_set;
            irq <= |(status & ien);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_seen <= '0;
        end else if (state == urxl_pkg::URXL_START) begin
            stop_seen <= '0;
        end else if (state == urxl_pkg::URXL_STOP && samp) begin
            stop_seen <= stop_seen + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_parity_gate: assert property ($past(state) == urxl_pkg::URXL_DATA && state == urxl_pkg::URXL_PARITY
        |-> cfg_par_on)
        else $error("parity bit taken with parity off");
    a_even_sense: assert property ((state == urxl_pkg::URXL_PARITY && samp && !cfg_fixed)
        |=> frame_perr == ($past(cfg_even) == ($past(^shreg) ^ $past(rx_line))))
        else $error("parity sense wrong");
    a_stop_count: assert property (char_done |-> stop_seen == (cfg_two_stop ? 2'h2 : 2'h1))
        else $error("stop bit count wrong");
    a_char_mode: assert property ((!line_ctl[urxl_pkg::URXL_LINE_QUEUE_ON] && q_cnt == 4'h1 && char_done && !pop)
        |=> status[urxl_pkg::URXL_ST_OVR] && q_cnt == 4'h1)
        else $error("holding word overrun missed");
    a_word_len: assert property ($past(state) == urxl_pkg::URXL_DATA && state != urxl_pkg::URXL_DATA
        |-> $past(bit_idx) == {1'b1, $past(line_ctl[urxl_pkg::URXL_LINE_LEN_LSB +: 2])})
        else $error("data bit count wrong");
    a_fixed_parity: assert property ((state == urxl_pkg::URXL_PARITY && samp && cfg_fixed)
        |=> frame_perr == ($past(rx_line) == $past(cfg_even)))
        else $error("fixed parity level wrong");
    a_div_frozen: assert property (state != urxl_pkg::URXL_IDLE |=> $stable(act_int) && $stable(act_frac))
        else $error("divisor changed inside a character");
    a_ovs_rate: assert property (samp |-> os_cnt == (act_ovs ? 5'h07 : 5'h0F))
        else $error("bit period not 16 or 8 ticks");
    a_irq_level: assert property (##1 irq == $past(|(status & ien)))
        else $error("interrupt level wrong");

    c_parity_frame: cover property (char_done && cfg_par_on);
    c_two_stop: cover property (char_done && cfg_two_stop);
    c_overrun: cover property ($rose(status[urxl_pkg::URXL_ST_OVR]));
    c_ovs8_frame: cover property (char_done && act_ovs);
endmodule
`default_nettype wire

// ===== bench/urxl_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module urxl_tx_model (
    // clock
    input wire logic pclk,
    // serial line
    output logic rx_line
);
    // the line idles at the mark level between frames
    initial rx_line = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // one frame, lsb first; every change lands just after a rising edge
    task automatic send(input logic [7:0] d, input int nbits, input logic par_en, input logic par_bit,
                        input int nstop, input logic bad_stop, input int bitc);
        rx_line <= 1'b0;
        repeat (bitc) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            rx_line <= d[i];
            repeat (bitc) @(posedge pclk);
        end
        if (par_en) begin
            rx_line <= par_bit;
            repeat (bitc) @(posedge pclk);
        end
        for (int i = 1; i <= nstop; i++) begin
            // a broken last stop is kept short so its tail cannot pass for a new start
            rx_line <= !(bad_stop && i == nstop);
            repeat ((bad_stop && i == nstop) ? bitc / 2 + 2 : bitc) @(posedge pclk);
        end
        rx_line <= 1'b1;
        repeat (bitc) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ===== bench/urxl_top_tb.sv
// self-checking testbench for the receive line control and baud divisor block
`timescale 1ns/100ps
`default_nettype none
module urxl_top_tb;
    localparam logic [11:0] A_LINE = urxl_pkg::URXL_ADDR_LINE;
    localparam logic [11:0] A_INT = urxl_pkg::URXL_ADDR_DIV_INT;
    localparam logic [11:0] A_FRAC = urxl_pkg::URXL_ADDR_DIV_FRAC;
    localparam logic [11:0] A_CTRL = urxl_pkg::URXL_ADDR_CTRL;
    localparam logic [11:0] A_STAT = urxl_pkg::URXL_ADDR_STAT;
    localparam logic [11:0] A_DATA = urxl_pkg::URXL_ADDR_DATA;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, rx_busy, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_mismatch, comparisons;
    logic [7:0] c_line [6] = '{8'h60, 8'h06, 8'h22, 8'hCE, 8'hC2, 8'h68};
    logic [7:0] c_data [6] = '{8'hA5, 8'h13, 8'h2D, 8'h55, 8'h3A, 8'h81};
    logic c_flip [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic c_bad [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    urxl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line(rx_line), .rx_busy(rx_busy), .irq(irq));
    urxl_tx_model tx_u (.pclk(pclk), .rx_line(rx_line));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            check("pready", 32'h1, 32'h0);
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // after a frame: irq up, status and data as expected, then clear drops irq
    task automatic end_frame(input logic [31:0] exp_st, input logic [31:0] exp_dat);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        check("irq raised", 32'h1, {31'h0, irq});
        if (irq !== 1'b1) wrap_up();
        rd_chk(A_STAT, exp_st, "status");
        rd_chk(A_DATA, exp_dat, "data");
        wr(urxl_pkg::URXL_ADDR_CLR, 32'h0000000F);
        @(posedge pclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        rd_chk(A_STAT, 32'h0, "status cleared");
    endtask

    task automatic run_frame(input logic [7:0] line, input logic [7:0] d, input logic flip, input logic bad,
                             input int bitc);
        int nb;
        logic [7:0] dm;
        logic pb;
        logic pe;
        nb = 5 + int'(line[6:5]);
        dm = d & 8'((1 << nb) - 1);
        pb = line[7] ? ~line[2] : (line[2] ? ^dm : ~^dm);
        pe = line[1] & flip;
        wr(A_LINE, {24'h0, line});
        tx_u.send(dm, nb, line[1], pb ^ flip, line[3] ? 2 : 1, bad, bitc);
        end_frame({29'h0, bad, pe, 1'b1}, {22'h0, bad, pe, dm});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(A_LINE, 32'h0, "line reset");
        rd_chk(A_INT, 32'h0, "whole reset");
        wr(A_LINE, 32'hFFFFFFFF);
        rd_chk(A_LINE, 32'h000000FF, "line rw");
        wr(A_INT, 32'hFFFFFFFF);
        rd_chk(A_INT, 32'h0000FFFF, "whole rw");
        wr(A_FRAC, 32'hFFFFFFFF);
        rd_chk(A_FRAC, 32'h0000003F, "fraction rw");
        apb(1'b0, 12'hFFC, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        $display("test registers done");
        wr(A_INT, 32'h1);
        wr(A_FRAC, 32'h0);
        wr(urxl_pkg::URXL_ADDR_IEN, 32'h0000000F);
        wr(A_CTRL, 32'h2);
        for (int i = 0; i < 6; i++) begin
            run_frame(c_line[i], c_data[i], c_flip[i], c_bad[i], 16);
        end
        $display("test framing done");
        wr(A_LINE, 32'h60);
        fork
            tx_u.send(8'h3C, 8, 1'b0, 1'b0, 1, 1'b0, 16);
            begin
                repeat (40) @(posedge pclk);
                check("busy mid frame", 32'h1, {31'h0, rx_busy});
                wr(A_INT, 32'h2);
            end
        join
        end_frame(32'h1, 32'h3C);
        run_frame(8'h60, 8'hC3, 1'b0, 1'b0, 32);
        wr(A_INT, 32'h1);
        wr(A_FRAC, 32'h20);
        run_frame(8'h60, 8'h5A, 1'b0, 1'b0, 24);
        wr(A_FRAC, 32'h0);
        wr(A_CTRL, 32'h3);
        run_frame(8'h60, 8'hE7, 1'b0, 1'b0, 8);
        $display("test divisor done");
        // interrupt masked here; the holding register overruns without the queue
        wr(urxl_pkg::URXL_ADDR_IEN, 32'h0);
        for (int m = 0; m < 2; m++) begin
            wr(A_LINE, m ? 32'h70 : 32'h60);
            tx_u.send(8'h11, 8, 1'b0, 1'b0, 1, 1'b0, 8);
            tx_u.send(8'h22, 8, 1'b0, 1'b0, 1, 1'b0, 8);
            check("irq masked", 32'h0, {31'h0, irq});
            rd_chk(A_STAT, m ? 32'h1 : 32'h9, "queue status");
            rd_chk(A_DATA, 32'h11, "first entry");
            rd_chk(A_DATA, m ? 32'h22 : 32'h400, "second entry");
            wr(urxl_pkg::URXL_ADDR_CLR, 32'h0000000F);
        end
        $display("test queue done");
        wrap_up();
    end
endmodule
`default_nettype wire
